// ---- hw/debug_enclave_read.sv ----
// Leaf executor for the debug enclave read of the enclave system instruction.
// Assumes memory data, map entry and mode inputs valid while start is high.
`timescale 1ns/1ps
`include "dbg_read_defines.svh"

module debug_enclave_read
  import dbg_read_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  input  wire logic                     start,
  input  wire logic [63:0]              error_code_in,
  input  wire logic [63:0]              address_operand_register,
  input  wire logic [63:0]              data_result_in,
  input  wire logic                     long_mode_active,
  input  wire logic                     cs_long,
  input  wire logic                     seg_violation,
  input  wire logic                     in_cache,
  input  wire logic                     map_busy,
  input  wire logic                     page_conflict,
  input  wire dbg_read_pkg::map_entry_s entry,
  input  wire logic [63:0]              mem_data,
  output      logic                     done_ff,
  output      logic                     general_protection_fault_ff,
  output      logic                     page_fault_exception_ff,
  output      logic [63:0]              fault_addr_ff,
  output      logic [15:0]              fault_code_ff,
  output      logic [63:0]              data_result_register_ff,
  output      logic [63:0]              error_code_register_ff,
  output      logic                     shared_hold_ff,
  output      dbg_read_pkg::flags_s     flags_ff
);

  // --------------------------------------------------------------------
  // Decode and checks
  // --------------------------------------------------------------------
  logic    go;
  logic    long_mode_flag;
  result_e result;
  logic [63:0] slot_val;
  logic [63:0] nxt_data;

  assign go = start && (error_code_in[7:0] == `LEAF_DEBUG_READ); // R1
  assign long_mode_flag = long_mode_active && cs_long; // R4

  check_order u_check (
    .long_mode     (long_mode_flag),
    .addr          (address_operand_register), // R3
    .seg_violation (seg_violation),
    .in_cache      (in_cache),
    .map_busy      (map_busy),
    .page_conflict (page_conflict),
    .entry         (entry),
    .result        (result)
  );

  // Version slots only reveal whether they are in use
  assign slot_val = mem_data & ~`SLOT_LOW_MASK; // R17
  always_comb
  begin
    if (entry.page_type == `PT_VERSION_ARRAY)
      nxt_data = (slot_val != 64'h0) ? 64'hffff_ffff_ffff_ffff : 64'h0; // R17
    else
      nxt_data = mem_data;
    // Width is fixed by mode; upper half of the result kept in short mode
    if (!long_mode_flag)
      nxt_data = {data_result_in[63:32], nxt_data[31:0]}; // R2
  end

  // --------------------------------------------------------------------
  // Completion pulse and fault reporting
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      done_ff                     <= 1'b0;
      general_protection_fault_ff <= 1'b0;
      page_fault_exception_ff     <= 1'b0;
      fault_addr_ff               <= 64'h0;
      fault_code_ff               <= 16'h0;
    end
    else
    begin
      done_ff                     <= go && (result == RES_OK || result == RES_ERR);
      general_protection_fault_ff <= go && (result == RES_GP); // R5 R6 R8
      page_fault_exception_ff     <= go && (result == RES_PF); // R7 R9
      if (go && result == RES_PF)
        fault_addr_ff <= address_operand_register;
      if (go && result == RES_GP)
        fault_code_ff <= `FAULT_CODE_ZERO;
    end
  end

  // Shared hold on the target page during the cycle of the read
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      shared_hold_ff <= 1'b0;
    else
      shared_hold_ff <= go && in_cache && !page_conflict; // R16
  end

  // --------------------------------------------------------------------
  // Architectural registers and flags
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      data_result_register_ff <= 64'h0;
      error_code_register_ff  <= 64'h0;
      flags_ff                <= '0;
    end
    else if (go && result == RES_OK)
    begin
      data_result_register_ff <= nxt_data; // R3 R17
      error_code_register_ff  <= `ERR_NONE; // R18
      flags_ff                <= '0; // R18
    end
    else if (go && result == RES_ERR)
    begin
      error_code_register_ff  <= `ERR_NOT_DEBUGGABLE; // R11
      flags_ff                <= '0;
      flags_ff.zf             <= 1'b1; // R11
    end
  end

endmodule // debug_enclave_read

// ---- hw/dbg_read_defines.svh ----
// Constants for the debug enclave read checker: codes, fields, limits.
// Assumes inclusion by the design modules only.
//
// Operation
// R1 - Leaf code 04H starts the debug read
// R2 - Eight bytes in long mode, else four
// R3 - Address operand in, data result out
// R4 - Long mode needs long-mode-active and segment long
// R5 - Long mode: misaligned to eight faults
// R6 - Otherwise misaligned to four faults
// R7 - Address outside page cache: page fault
// R8 - Concurrent map modifier: protection fault
// R9 - Invalid map entry: page fault
// R10 - Control structure page type faults
// R11 - Pending or modified: error, zero flag
// R12 - Non-debug enclave faults
// R13 - Thread structure offset beyond limit faults
// R14 - Segment violation on operand faults
// R15 - Read/write/execute attributes are not checked
// R16 - Shared page access; conflict gives protection fault
// R17 - Version slot: all ones if nonzero
// R18 - Success clears error and flags
// R19 - Checks in fixed order, first reported
`ifndef DBG_READ_DEFINES_SVH
`define DBG_READ_DEFINES_SVH

`define LEAF_DEBUG_READ       8'h04
`define PT_REGULAR            3'h1
`define PT_THREAD             3'h2
`define PT_VERSION_ARRAY      3'h3
`define PT_CONTROL            3'h0
`define ERR_NOT_DEBUGGABLE    64'h0000_0000_0000_0007
`define ERR_NONE              64'h0
`define THREAD_LIMIT          12'h048
`define PAGE_OFFSET_MASK      64'h0000_0000_0000_0fff
`define SLOT_LOW_MASK         64'h0000_0000_0000_0007
`define FAULT_CODE_ZERO       16'h0000

`endif

// ---- hw/dbg_read_pkg.sv ----
// Types shared by the debug enclave read checker.
// Assumes the defines header sits alongside.
package dbg_read_pkg;

  // Outcome of one read
  typedef enum logic [3:0] {
    RES_OK    = 4'b0001,
    RES_GP    = 4'b0010,
    RES_PF    = 4'b0100,
    RES_ERR   = 4'b1000
  } result_e;

  // Map entry as returned by the page cache map lookup
  typedef struct packed {
    logic       valid;
    logic [2:0] page_type;
    logic       pending;
    logic       modified;
    logic       debug_enclave;
  } map_entry_s;

  // Architectural flag outputs
  typedef struct packed {
    logic zf;
    logic cf;
    logic pf;
    logic af;
    logic of_flag;
    logic sf;
  } flags_s;

endpackage

// ---- hw/check_order.sv ----
// Priority checker: picks the first failing check of a debug read.
// Assumes all inputs steady for the cycle in which start is sampled.
`timescale 1ns/1ps
`include "dbg_read_defines.svh"

module check_order
  import dbg_read_pkg::*;
(
  input  wire logic                    long_mode,
  input  wire logic [63:0]             addr,
  input  wire logic                    seg_violation,
  input  wire logic                    in_cache,
  input  wire logic                    map_busy,
  input  wire logic                    page_conflict,
  input  wire dbg_read_pkg::map_entry_s entry,
  output      dbg_read_pkg::result_e   result
);

  logic misaligned;
  logic bad_type;
  logic thread_over;
  logic [11:0] page_off;

  // Alignment follows the width of the transfer
  assign misaligned = long_mode ? (addr[2:0] != 3'h0) : (addr[1:0] != 2'h0); // R5 R6
  assign bad_type = (entry.page_type != `PT_REGULAR) && (entry.page_type != `PT_THREAD)
                    && (entry.page_type != `PT_VERSION_ARRAY); // R10
  assign page_off = addr[11:0];
  assign thread_over = (entry.page_type == `PT_THREAD) && (page_off >= `THREAD_LIMIT); // R13

  // First failure wins; permission bits are deliberately never looked at
  always_comb
  begin
    if (seg_violation || misaligned)
      result = RES_GP; // R14 R19
    else if (!in_cache)
      result = RES_PF; // R7
    else if (map_busy || page_conflict)
      result = RES_GP; // R8 R16
    else if (!entry.valid)
      result = RES_PF; // R9
    else if (bad_type)
      result = RES_PF; // R10
    else if (entry.pending || entry.modified)
      result = RES_ERR; // R11
    else if (thread_over)
      result = RES_GP; // R13
    else if ((entry.page_type != `PT_VERSION_ARRAY) && !entry.debug_enclave)
      result = RES_GP; // R12 R15
    else
      result = RES_OK;
  end

endmodule // check_order

// ---- tb/read_monitor.sv ----
// Port-level assertions for the debug read leaf executor.
// Assumes binding onto debug_enclave_read, one clock domain.
`timescale 1ns/1ps
module read_monitor
  import dbg_read_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic start,
  input wire logic [63:0] error_code_in,
  input wire logic [63:0] address_operand_register,
  input wire logic long_mode_active,
  input wire logic cs_long,
  input wire logic seg_violation,
  input wire logic in_cache,
  input wire logic map_busy,
  input wire logic page_conflict,
  input wire dbg_read_pkg::map_entry_s entry,
  input wire logic done_ff,
  input wire logic general_protection_fault_ff,
  input wire logic page_fault_exception_ff,
  input wire logic [63:0] fault_addr_ff,
  input wire logic [63:0] error_code_register_ff,
  input wire dbg_read_pkg::flags_s flags_ff
);
  // ------------------
  // Decode and checks
  // ------------------
  logic m64, go, ok, hit, typ;
  logic [2:0] o;
  // Alignment follows the operating width, so decode it once
  assign m64 = long_mode_active & cs_long;
  assign go = start && error_code_in[7:0] == 8'h04;
  assign ok = go && !seg_violation && (m64 ? address_operand_register[2:0] == 3'h0
    : address_operand_register[1:0] == 2'h0);
  assign hit = ok && in_cache && !map_busy && !page_conflict && entry.valid;
  assign typ = entry.page_type inside {3'h1, 3'h2, 3'h3};
  assign o = {done_ff, general_protection_fault_ff, page_fault_exception_ff};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_take; go |=> $onehot(o); endproperty
  a_take: assert property (p_take) else $error("no single answer");
  property p_wide; go && m64 && !seg_violation && address_operand_register[2:0] == 3'h4
    |=> o == 3'h2; endproperty
  a_wide: assert property (p_wide) else $error("long misalign");
  property p_narrow; go && !m64 && address_operand_register[1:0] != 2'h0 |=> o == 3'h2;
  endproperty
  a_narrow: assert property (p_narrow) else $error("short misalign");
  property p_cache; ok && !in_cache |=> o == 3'h1
    && fault_addr_ff == $past(address_operand_register); endproperty
  a_cache: assert property (p_cache) else $error("outside cache");
  property p_busy; ok && in_cache && (map_busy || page_conflict) |=> o == 3'h2; endproperty
  a_busy: assert property (p_busy) else $error("busy map");
  property p_ctl; hit && !typ |=> o == 3'h1; endproperty
  a_ctl: assert property (p_ctl) else $error("bad page type");
  property p_pend; hit && typ && (entry.pending || entry.modified)
    |=> done_ff && flags_ff.zf && error_code_register_ff == 64'h7; endproperty
  a_pend: assert property (p_pend) else $error("pending page");
  property p_done; done_ff |-> flags_ff[4:0] == 5'h0
    && (flags_ff.zf || error_code_register_ff == 64'h0); endproperty
  a_done: assert property (p_done) else $error("completion flags");
  c_ok: cover property (o == 3'h4 && !flags_ff.zf);
  c_gp: cover property (o == 3'h2);
  c_pf: cover property (o == 3'h1);
endmodule // read_monitor

bind debug_enclave_read read_monitor read_monitor_inst (.*);

// ---- tb/debug_enclave_read_checker_bench.sv ----
// Self-checking bench for the debug read leaf executor.
// Assumes the design and the bound monitor are compiled first.
`timescale 1ns/1ps
module debug_enclave_read_checker_bench;
  import dbg_read_pkg::*;
  // ------------------
  // Stimulus and checks
  // ------------------
  typedef struct packed {
    logic [1:0] md; logic [63:0] a; logic [3:0] c; logic [6:0] e;
    logic [63:0] m; logic [2:0] x; logic z; logic [63:0] d;
  } row_s;
  localparam logic [63:0] M = 64'h1122334455667788;
  localparam logic [63:0] Q = 64'haaaaaaaa55555555;
  logic clk_sys = 0, resetn = 0, start = 0, long_mode_active = 0, cs_long = 0;
  logic seg_violation = 0, in_cache = 0, map_busy = 0, page_conflict = 0;
  logic [63:0] error_code_in = 0, address_operand_register = 0, mem_data = 0;
  logic [63:0] data_result_in = Q, fault_addr_ff, data_result_register_ff;
  logic [63:0] error_code_register_ff;
  logic [15:0] fault_code_ff;
  logic done_ff, general_protection_fault_ff, page_fault_exception_ff, shared_hold_ff;
  map_entry_s entry = '0;
  flags_s flags_ff;
  int n_mismatch = 0, num_checks = 0;
  row_s r;
  wire [2:0] o = {done_ff, general_protection_fault_ff, page_fault_exception_ff};
  // Mode, address, {seg,cache,busy,conflict}, entry, memory, answer, zf, data
  row_s rows[17] = '{
    '{3, 8, 4, 'h49, M, 4, 0, M},
    '{2, 4, 4, 'h49, M, 4, 0, {Q[63:32], M[31:0]}},
    '{1, 4, 4, 'h49, M, 4, 0, {Q[63:32], M[31:0]}},
    '{3, 4, 4, 'h49, M, 2, 0, 0},
    '{0, 2, 4, 'h49, M, 2, 0, 0},
    '{3, 8, 'hc, 'h49, M, 2, 0, 0},
    '{3, 8, 2, 'h49, M, 1, 0, 0},
    '{3, 8, 6, 'h09, M, 2, 0, 0},
    '{3, 8, 5, 'h49, M, 2, 0, 0},
    '{3, 8, 4, 'h09, M, 1, 0, 0},
    '{3, 8, 4, 'h41, M, 1, 0, 0},
    '{3, 8, 4, 'h4d, M, 4, 1, 0},
    '{3, 'h1048, 4, 'h51, M, 2, 0, 0},
    '{3, 'h1040, 4, 'h51, M, 4, 0, M},
    '{3, 8, 4, 'h48, M, 2, 0, 0},
    '{3, 8, 4, 'h58, 7, 4, 0, 0},
    '{3, 8, 4, 'h58, 8, 4, 0, '1}
  };

  debug_enclave_read debug_enclave_read_inst (.*);

  task automatic chk(input string s, input logic [63:0] v, x);
    num_checks++;
    if (v !== x)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", s, x, v);
    end
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Free-running system clock
  initial forever #50 clk_sys = ~clk_sys;

  // Watchdog, about six times the expected run
  initial
  begin
    #30000;
    n_mismatch++;
    conclude;
  end

  // Reset, a refused leaf, then the rows back to back
  initial
  begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    error_code_in <= 64'h5;
    start <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk("refused", {o, flags_ff}, 0);
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      r = rows[i];
      error_code_in <= 64'h4;
      {long_mode_active, cs_long} <= r.md;
      address_operand_register <= r.a;
      {seg_violation, in_cache, map_busy, page_conflict} <= r.c;
      entry <= r.e;
      mem_data <= r.m;
      @(posedge clk_sys);
      #1 chk("answer", o, r.x);
      chk("shared hold", shared_hold_ff, r.c[2] && !r.c[0]);
      if (r.x == 3'h2)
        chk("fault code", fault_code_ff, 0);
      if (r.x == 3'h1)
        chk("fault address", fault_addr_ff, r.a);
      if (r.x == 3'h4)
      begin
        chk("zero flag", flags_ff.zf, r.z);
        chk("error code", error_code_register_ff, r.z ? 64'h7 : 64'h0);
        chk("flags", flags_ff[4:0], 0);
        if (!r.z)
          chk("data", data_result_register_ff, r.d);
      end
    end
    // Mid-run reset with the last request still standing
    @(posedge clk_sys);
    resetn <= 1'b0;
    @(posedge clk_sys);
    #1 chk("reset outputs", {o, flags_ff, shared_hold_ff}, 0);
    chk("reset data", data_result_register_ff, 0);
    chk("reset error", error_code_register_ff, 0);
    @(posedge clk_sys);
    resetn <= 1'b1;
    // First request after release is taken at the next edge
    @(posedge clk_sys);
    #1 chk("after reset", o, 3'h4);
    chk("after reset data", data_result_register_ff, '1);
    conclude;
  end
endmodule // debug_enclave_read_checker_bench
